/* File: acs_pkg.sv */
/*
 * acs_pkg: shared constants for the axis comparator 3/4 setup block:
 * register offsets, field positions of the environment setup word,
 * method, action and source codes, index pulse states and timing.
 * Assumes a 32-bit APB bus with byte addresses on word boundaries.
 */
package acs_pkg;
	// bus geometry
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_ENV4 = 8'h00;   // environment four word
	localparam logic [7:0] OFS_CMP1 = 8'h04;   // compare data 1
	localparam logic [7:0] OFS_CMP2 = 8'h08;   // compare data 2
	localparam logic [7:0] OFS_CMP3 = 8'h0c;   // compare data 3
	localparam logic [7:0] OFS_CMP4 = 8'h10;   // compare data 4
	localparam logic [7:0] OFS_ISTAT = 8'h14;  // sticky event status, ro
	localparam logic [7:0] OFS_ICLR = 8'h18;   // event clear, wo
	localparam logic [7:0] OFS_IEN = 8'h1c;    // event enable
	localparam logic [7:0] OFS_LIVE = 8'h20;   // live match state, ro

	// reset values
	localparam logic [31:0] RST_ENV4 = 32'h0000_0000;
	localparam logic [31:0] RST_CMP = 32'h0000_0000;
	localparam logic [4:0] RST_IEN = 5'h00;

	// field positions inside the environment four word
	localparam int F_C1SRC = 0;    // cmp1 source, 2 bits
	localparam int F_C1MTH = 2;    // cmp1_method_sel, 3 bits
	localparam int F_C1ACT = 5;    // cmp1 action, 2 bits
	localparam int F_C2SRC = 8;
	localparam int F_C2MTH = 10;   // cmp2_method_sel
	localparam int F_C2ACT = 13;
	localparam int F_C3SRC = 16;   // cmp3 source
	localparam int F_C3MTH = 18;   // cmp3_method_sel
	localparam int F_C3ACT = 21;   // cmp3_action_sel
	localparam int F_INDEX_MODE_BIT = 23;    // index_mode_bit
	localparam int F_C4SRC = 24;   // cmp4_source_sel
	localparam int F_C4MTH = 26;   // cmp4_method_sel, 4 bits
	localparam int F_C4ACT = 30;   // cmp4_action_sel

	// comparison method codes (4-bit form; 3-bit fields are zero extended)
	localparam logic [3:0] M_EQ_ANY = 4'h1;
	localparam logic [3:0] M_EQ_UP = 4'h2;
	localparam logic [3:0] M_EQ_DN = 4'h3;
	localparam logic [3:0] M_GT = 4'h4;     // data greater than counter
	localparam logic [3:0] M_LT = 4'h5;     // data less than counter
	localparam logic [3:0] M_SWLIM = 4'h6;  // software limit, cmp1/cmp2
	localparam logic [3:0] M_IDX_ANY = 4'h8;
	localparam logic [3:0] M_IDX_ALT = 4'h9;
	localparam logic [3:0] M_IDX_DN = 4'ha;

	// match action codes
	localparam logic [1:0] A_NONE = 2'h0;
	localparam logic [1:0] A_ISTOP = 2'h1;
	localparam logic [1:0] A_DSTOP = 2'h2;
	localparam logic [1:0] A_SPEED = 2'h3;

	// comparison source codes
	localparam logic [1:0] S_CMD = 2'h0;
	localparam logic [1:0] S_MECH = 2'h1;
	localparam logic [1:0] S_DEFL = 2'h2;
	localparam logic [1:0] S_GEN = 2'h3;

	// deflection absolute ceiling
	localparam logic [15:0] DEFL_ABS_MAX = 16'h7fff;

	// index pulse width in reference clocks
	localparam int IDX_PULSE_CYCLES = 2;

	// index pulse sequencer, gray from IDX_IDLE through IDX_HI1 to IDX_HI2; both bits change on the return to IDX_IDLE
	typedef enum logic [1:0] {
		IDX_IDLE = 2'b00,
		IDX_HI1 = 2'b01,
		IDX_HI2 = 2'b11
	} acs_idx_state_t;
endpackage : acs_pkg

/* File: acs_comparator_top.sv */
/*
 * acs_comparator_top: comparators 1 to 4 of one axis with software limits,
 * match actions, index output and an APB register slave with interrupts.
 * Assumes counters and direction flags come from the axis counter logic,
 * synchronous to pclk, and that the axis motion logic consumes the
 * one-cycle stop and speed change requests.
 */
// Overview of operation
// - cmp3 method: eq any, up, down, gt, lt
// - cmp3 code 110 and unlisted never match
// - cmp3 action: none, istop, dstop, speed change
// - cmp4 action uses the same four codes
// - index mode 0: index while general equals data2
// - index mode 1: two-cycle pulse at general zero
// - cmp4 source: command, mechanical, deflection, general
// - cmp4 method: eq any, up, down, gt, lt
// - cmp4 codes 1000 to 1010 compare general with data4, 1010 counting down only
// - cmp4 0111 and unassigned codes never match
// - deflection source compares absolute value, 0 to 32767
// - software limit stops regardless of action field
// - limit with dstop decelerates only at high speed
// - cmp3 source: command, mechanical, deflection, general
// - code 110: cmp1 positive, cmp2 negative limit
module acs_comparator_top #(
	parameter int CNT_W = 28    // width of the position counters
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acs_pkg::ADDR_W-1:0] paddr,
	input wire logic [acs_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [acs_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [CNT_W-1:0] command_position_counter,
	input wire logic signed [CNT_W-1:0] mechanical_position_counter,
	input wire logic signed [15:0] deflection_counter,
	input wire logic signed [CNT_W-1:0] general_counter,
	input wire logic [3:0] count_dir_up,
	input wire logic high_speed,
	output logic index_output,
	output logic [3:0] cmp_match,
	output logic stop_immediate,
	output logic stop_decel,
	output logic speed_change,
	output logic irq
);
	import acs_pkg::*;

	// registers
	logic [31:0] env4_r;                        // environment four setup
	logic signed [CNT_W-1:0] cdata_r [0:3];     // compare data 1..4
	logic [4:0] istat_r;                        // matches 1..4, limit stop
	logic [4:0] ien_r;                          // event enables
	logic [DATA_W-1:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// combinational comparison results
	logic [3:0] match_now;
	logic [3:0] match_q;                        // previous cycle, for edges
	logic swlim_now;
	logic swlim_q;
	logic idx_level;
	logic signed [CNT_W-1:0] gen_q;             // previous general counter
	acs_idx_state_t idx_st_r;
	acs_idx_state_t idx_st_nxt;

	// bus phase decode
	logic acc;
	logic wr_acc;
	logic mapped;
	assign acc = psel & penable & pready_r;
	assign wr_acc = acc & pwrite;

	// evaluate one comparison method; unlisted codes never match
	function automatic logic cmp_eval(input logic [3:0] mth,
		input logic signed [CNT_W-1:0] dat,
		input logic signed [CNT_W-1:0] val, input logic up);
		logic r;
		r = 1'b0;
		case (mth)
		M_EQ_ANY: r = (dat == val);
		M_EQ_UP: r = (dat == val) & up;
		M_EQ_DN: r = (dat == val) & ~up;
		M_GT: r = (dat > val);
		M_LT: r = (dat < val);
		default: r = 1'b0;
		endcase
		return r;
	endfunction : cmp_eval

	// absolute deflection, -32768 clamped so the range stays 0..32767
	function automatic logic signed [CNT_W-1:0] defl_abs(
		input logic signed [15:0] d);
		logic [15:0] a;
		a = d[15] ? 16'(-d) : d;
		if (a > DEFL_ABS_MAX) begin
			a = DEFL_ABS_MAX;
		end
		return CNT_W'(a);
	endfunction : defl_abs

	// pick the compared counter for a source code
	function automatic logic signed [CNT_W-1:0] src_val(
		input logic [1:0] s);
		logic signed [CNT_W-1:0] v;
		v = command_position_counter;
		case (s)
		S_CMD: v = command_position_counter;
		S_MECH: v = mechanical_position_counter;
		S_DEFL: v = defl_abs(deflection_counter);
		S_GEN: v = general_counter;
		default: v = command_position_counter;
		endcase
		return v;
	endfunction : src_val

	// direction of the selected counter, deflection uses its own flag
	function automatic logic src_up(input logic [1:0] s);
		return count_dir_up[s];
	endfunction : src_up

	// field views
	logic [1:0] c1s, c2s, c3s, c4s;
	logic [3:0] c1m, c2m, c3m, c4m;
	logic [1:0] c1a, c2a, c3a, c4a;
	assign c1s = env4_r[F_C1SRC+:2];
	assign c2s = env4_r[F_C2SRC+:2];
	assign c3s = env4_r[F_C3SRC+:2];
	assign c4s = env4_r[F_C4SRC+:2];
	assign c1m = {1'b0, env4_r[F_C1MTH+:3]};
	assign c2m = {1'b0, env4_r[F_C2MTH+:3]};
	assign c3m = {1'b0, env4_r[F_C3MTH+:3]};
	assign c4m = env4_r[F_C4MTH+:4];
	assign c1a = env4_r[F_C1ACT+:2];
	assign c2a = env4_r[F_C2ACT+:2];
	assign c3a = env4_r[F_C3ACT+:2];
	assign c4a = env4_r[F_C4ACT+:2];

	// index codes on comparator 4
	logic c4_idx;
	logic c4_dir_ok;
	assign c4_idx = (c4m == M_IDX_ANY) | (c4m == M_IDX_ALT) |
		(c4m == M_IDX_DN);
	assign c4_dir_ok = (c4m != M_IDX_DN) | ~count_dir_up[S_GEN];

	// all conditions evaluated every clock on the present values
	always_comb begin
		// cmp1/cmp2: code 110 is a limit on the command counter
		match_now[0] = (c1m == M_SWLIM) ?
			(command_position_counter > cdata_r[0]) :
			cmp_eval(c1m, cdata_r[0], src_val(c1s), src_up(c1s));
		match_now[1] = (c2m == M_SWLIM) ?
			(command_position_counter < cdata_r[1]) :
			cmp_eval(c2m, cdata_r[1], src_val(c2s), src_up(c2s));
		// cmp3: 3-bit code, 110 falls into never-match
		match_now[2] = cmp_eval(c3m, cdata_r[2], src_val(c3s),
			src_up(c3s));
		// cmp4: index codes compare the general counter with data 4
		if (c4_idx) begin
			match_now[3] = (general_counter == cdata_r[3]) & c4_dir_ok;
		end else begin
			match_now[3] = cmp_eval(c4m, cdata_r[3], src_val(c4s),
				src_up(c4s));
		end
		// a limit in force, whatever its action field says
		swlim_now = ((c1m == M_SWLIM) & match_now[0]) |
			((c2m == M_SWLIM) & match_now[1]);
	end

	// edges of match state and general counter history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 4'h0;
			swlim_q <= 1'b0;
			gen_q <= '0;
		end else begin
			match_q <= match_now;
			swlim_q <= swlim_now;
			gen_q <= general_counter;
		end
	end

	// registered live match flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_match <= 4'h0;
		end else begin
			cmp_match <= match_now;
		end
	end

	// motion requests, one cycle on the rising edge of a condition;
	// a limit rising edge overrides the comparator's own action
	logic [3:0] rise;
	logic lim_rise;
	logic [1:0] lim_act;
	assign rise = match_now & ~match_q;
	assign lim_rise = swlim_now & ~swlim_q;
	assign lim_act = ((c1m == M_SWLIM) & match_now[0]) ? c1a : c2a;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_immediate <= 1'b0;
			stop_decel <= 1'b0;
			speed_change <= 1'b0;
		end else begin
			stop_immediate <= 1'b0;
			stop_decel <= 1'b0;
			speed_change <= 1'b0;
			if (lim_rise) begin
				// decelerate only from high speed, else stop at once
				if (lim_act == A_DSTOP && high_speed) begin
					stop_decel <= 1'b1;
				end else begin
					stop_immediate <= 1'b1;
				end
			end else begin
				// cmp1/cmp2 ordinary plus cmp3/cmp4 actions
				if ((rise[0] && c1a == A_ISTOP) || (rise[1] && c2a == A_ISTOP) ||
					(rise[2] && c3a == A_ISTOP) ||
					(rise[3] && c4a == A_ISTOP)) begin
					stop_immediate <= 1'b1;
				end else if ((rise[0] && c1a == A_DSTOP) ||
					(rise[1] && c2a == A_DSTOP) ||
					(rise[2] && c3a == A_DSTOP) ||
					(rise[3] && c4a == A_DSTOP)) begin
					stop_decel <= 1'b1;
				end
				// speed change independent of stops; A_NONE only flags
				speed_change <= (rise[0] && c1a == A_SPEED) ||
					(rise[1] && c2a == A_SPEED) ||
					(rise[2] && c3a == A_SPEED) ||
					(rise[3] && c4a == A_SPEED);
			end
		end
	end

	// index pulse sequencer: general counter reaching zero by counting
	logic gen_zero_hit;
	assign gen_zero_hit = (general_counter == '0) & (gen_q != '0) &
		c4_dir_ok;

	always_comb begin
		idx_st_nxt = idx_st_r;
		case (idx_st_r)
		IDX_IDLE: if (gen_zero_hit) begin
			idx_st_nxt = IDX_HI1;
		end
		IDX_HI1: idx_st_nxt = IDX_HI2;
		IDX_HI2: idx_st_nxt = gen_zero_hit ? IDX_HI1 : IDX_IDLE;
		default: idx_st_nxt = IDX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_st_r <= IDX_IDLE;
		end else begin
			idx_st_r <= env4_r[F_INDEX_MODE_BIT] ? idx_st_nxt : IDX_IDLE;
		end
	end

	// index output: level in mode 0, two-clock pulse in mode 1
	// (IDX_PULSE_CYCLES states are high in the sequencer)
	assign idx_level = env4_r[F_INDEX_MODE_BIT] ?
		(idx_st_nxt != IDX_IDLE) :
		((general_counter == cdata_r[1]) & c4_dir_ok);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_output <= 1'b0;
		end else begin
			index_output <= idx_level;
		end
	end

	// address decode
	always_comb begin
		case (paddr)
		OFS_ENV4, OFS_CMP1, OFS_CMP2, OFS_CMP3, OFS_CMP4, OFS_ISTAT,
		OFS_ICLR, OFS_IEN, OFS_LIVE: mapped = 1'b1;
		default: mapped = 1'b0;
		endcase
	end

	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) begin
			m[8*i+:8] = pstrb[i] ? pwdata[8*i+:8] : old[8*i+:8];
		end
		return m;
	endfunction : merge

	// environment and compare data registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			env4_r <= RST_ENV4;
			for (int i = 0; i < 4; i++) begin
				cdata_r[i] <= CNT_W'(RST_CMP);
			end
		end else if (wr_acc) begin
			case (paddr)
			OFS_ENV4: env4_r <= merge(env4_r);
			OFS_CMP1: cdata_r[0] <= CNT_W'(merge(32'(cdata_r[0])));
			OFS_CMP2: cdata_r[1] <= CNT_W'(merge(32'(cdata_r[1])));
			OFS_CMP3: cdata_r[2] <= CNT_W'(merge(32'(cdata_r[2])));
			OFS_CMP4: cdata_r[3] <= CNT_W'(merge(32'(cdata_r[3])));
			default: ;
			endcase
		end
	end

	// event enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_r <= RST_IEN;
		end else if (wr_acc && paddr == OFS_IEN && pstrb[0]) begin
			ien_r <= pwdata[4:0];
		end
	end

	// sticky events; a new event in the clear cycle wins over the clear
	logic [4:0] ev_set;
	logic [4:0] ev_clr;
	assign ev_set = {lim_rise, rise};
	assign ev_clr = (wr_acc && paddr == OFS_ICLR && pstrb[0]) ?
		pwdata[4:0] : 5'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_r <= 5'h00;
			irq <= 1'b0;
		end else begin
			istat_r <= (istat_r & ~ev_clr) | ev_set;
			irq <= |(((istat_r & ~ev_clr) | ev_set) & ien_r);
		end
	end

	// apb answer: ready rises in the access phase, one cycle per transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= psel & ~penable & ~pready_r;
			pslverr_r <= psel & ~penable & ~mapped;
			prdata_r <= '0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
				OFS_ENV4: prdata_r <= env4_r;
				OFS_CMP1: prdata_r <= 32'(cdata_r[0]);
				OFS_CMP2: prdata_r <= 32'(cdata_r[1]);
				OFS_CMP3: prdata_r <= 32'(cdata_r[2]);
				OFS_CMP4: prdata_r <= 32'(cdata_r[3]);
				OFS_ISTAT: prdata_r <= {27'h0, istat_r};
				OFS_IEN: prdata_r <= {27'h0, ien_r};
				OFS_LIVE: prdata_r <= {26'h0, index_output, swlim_q, cmp_match};
				default: prdata_r <= '0;   // clear register reads zero
				endcase
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule : acs_comparator_top

/* File: acs_top_chk.sv */
/*
 * acs_top_chk: concurrent checks on the comparator block's ports.
 * Assumes the bench writes whole words (all byte lanes) so that a
 * shadow of the setup, compare 2 and enable words can be kept here.
 */
module acs_top_chk #(
	parameter int CNT_W = 28    // width of the position counters
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acs_pkg::ADDR_W-1:0] paddr,
	input wire logic [acs_pkg::DATA_W-1:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signed [CNT_W-1:0] general_counter,
	input wire logic [3:0] count_dir_up,
	input wire logic index_output,
	input wire logic [3:0] cmp_match,
	input wire logic stop_immediate,
	input wire logic stop_decel,
	input wire logic speed_change,
	input wire logic irq
);
	import acs_pkg::*;
	logic [31:0] env_r;    // shadow of the setup word
	logic [31:0] cmp2_r;   // shadow of compare data 2
	logic [4:0] ien_r;     // shadow of the event enables
	logic idx_lvl;         // index level expected in mode 0
	assign idx_lvl = !env_r[F_INDEX_MODE_BIT]
		&& general_counter == cmp2_r[CNT_W-1:0]
		&& (env_r[29:26] != M_IDX_DN || !count_dir_up[3]);
	// shadows follow completed writes only, as the slave does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			env_r <= RST_ENV4;
			cmp2_r <= RST_CMP;
			ien_r <= RST_IEN;
		end else if (psel && penable && pready && pwrite) begin
			if (paddr == OFS_ENV4) env_r <= pwdata;
			if (paddr == OFS_CMP2) cmp2_r <= pwdata;
			if (paddr == OFS_IEN) ien_r <= pwdata[4:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready_access; psel && penable |-> pready; endproperty
	property p_ready_only; pready |-> psel && penable; endproperty
	property p_err_ready; pslverr |-> pready; endproperty
	property p_istop_one; stop_immediate |=> !stop_immediate; endproperty
	property p_no_both; stop_decel |-> !stop_immediate; endproperty
	// a speed change is only ever launched by a fresh match
	property p_spd_cause;
		speed_change |-> (cmp_match & ~$past(cmp_match)) != 4'h0;
	endproperty
	property p_idx_pulse;
		$past(presetn) && env_r[F_INDEX_MODE_BIT] && $rose(index_output)
			|=> index_output ##1 !index_output;
	endproperty
	// past reset guard: the flop still held its reset value
	property p_idx_level;
		$past(presetn) && !$past(env_r[F_INDEX_MODE_BIT])
			|-> index_output == $past(idx_lvl);
	endproperty
	property p_irq_off;
		$past(presetn) && ien_r == 5'h0 && $past(ien_r) == 5'h0 |-> !irq;
	endproperty
	a_ready_access: assert property (p_ready_access)
		else $error("no ready in access cycle");
	a_ready_only: assert property (p_ready_only)
		else $error("ready outside access cycle");
	a_err_ready: assert property (p_err_ready)
		else $error("error without ready");
	a_istop_one: assert property (p_istop_one)
		else $error("stop pulse longer than one cycle");
	a_no_both: assert property (p_no_both)
		else $error("both stop kinds at once");
	a_spd_cause: assert property (p_spd_cause)
		else $error("speed change without new match");
	a_idx_pulse: assert property (p_idx_pulse)
		else $error("index pulse not two cycles");
	a_idx_level: assert property (p_idx_level)
		else $error("index level wrong");
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt with no enables");
	c_istop: cover property (stop_immediate);
	c_idx: cover property (env_r[F_INDEX_MODE_BIT] && index_output);
	c_err: cover property (pslverr);
endmodule : acs_top_chk

bind acs_comparator_top acs_top_chk #(.CNT_W(CNT_W)) chk_u (.*);

/* File: test_axis_comparator_three_four_setup.sv */
/*
 * test_axis_comparator_three_four_setup: table driven bench for the
 * comparator block, then index, limit, interrupt and reset cases.
 * Assumes the package constants and an answer in one access cycle.
 */
module test_axis_comparator_three_four_setup;
	timeunit 1ns;
	timeprecision 1ps;
	import acs_pkg::*;
	localparam int CW = 28;  // counter width handed to the design
	typedef struct {
		logic [31:0] env, d;
		int src, pre, cnt;
		logic up;
		logic [3:0] m;
		logic [2:0] a;
	} acs_row_t;
	acs_row_t rows[$];  // ordinary cases
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hs, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, dir_v, cmp_match;
	logic signed [CW-1:0] cnt_v [4];  // indexed by source code
	logic signed [15:0] defl_v;
	logic index_output, stop_immediate, stop_decel, speed_change, irq;
	int n_fail, checked;
	acs_comparator_top #(.CNT_W(CW)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.command_position_counter(cnt_v[0]),
		.mechanical_position_counter(cnt_v[1]),
		.deflection_counter(defl_v), .general_counter(cnt_v[3]),
		.count_dir_up(dir_v), .high_speed(hs),
		.index_output(index_output), .cmp_match(cmp_match),
		.stop_immediate(stop_immediate), .stop_decel(stop_decel),
		.speed_change(speed_change), .irq(irq));
	// free running reference clock
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	task close_out;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// one transfer; the request holds until ready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	function automatic logic [31:0] mk(input int s3, m3, a3, s4, m4, a4);
		return {a4[1:0], m4[3:0], s4[1:0], 1'h0, a3[1:0], m3[2:0],
			s3[1:0], 16'h0};
	endfunction : mk
	task add(input logic [31:0] env, input int d, src, pre, cnt,
		input logic up, input logic [3:0] m, input logic [2:0] a);
		rows.push_back('{env, 32'(d), src, pre, cnt, up, m, a});
	endtask : add
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		close_out();
	end
	initial begin
		{presetn, psel, penable, pwrite, hs, paddr, pwdata} = '0;
		pstrb = 4'hf;
		cnt_v = '{default: '0};
		defl_v = 16'h0;
		dir_v = 4'h0;
		add(mk(0, 1, 1, 0, 0, 0), 100, 0, 0, 100, 1, 4, 4);
		add(mk(1, 2, 2, 0, 0, 0), 100, 1, 0, 100, 1, 4, 2);
		add(mk(1, 2, 2, 0, 0, 0), 100, 1, 0, 100, 0, 0, 0);
		add(mk(3, 3, 3, 0, 0, 0), 100, 3, 0, 100, 0, 4, 1);
		add(mk(0, 4, 0, 0, 0, 0), 100, 0, 200, 50, 0, 4, 0);
		add(mk(0, 5, 0, 0, 0, 0), 100, 0, 50, 200, 0, 4, 0);
		add(mk(0, 6, 1, 0, 0, 0), 100, 0, 0, 100, 0, 0, 0);
		add(mk(0, 7, 1, 0, 0, 0), 100, 0, 0, 100, 0, 0, 0);
		add(mk(2, 1, 0, 0, 0, 0), 32767, 2, 0, -32768, 0, 4, 0);
		add(mk(0, 0, 0, 0, 1, 1), 100, 0, 0, 100, 0, 8, 4);
		add(mk(0, 0, 0, 1, 2, 2), 100, 1, 0, 100, 1, 8, 2);
		add(mk(0, 0, 0, 1, 2, 2), 100, 1, 0, 100, 0, 0, 0);
		add(mk(0, 0, 0, 3, 3, 3), 100, 3, 0, 100, 0, 8, 1);
		add(mk(0, 0, 0, 2, 1, 0), 300, 2, 0, -300, 0, 8, 0);
		add(mk(0, 0, 0, 0, 4, 0), 100, 0, 200, 50, 0, 8, 0);
		add(mk(0, 0, 0, 0, 5, 0), 100, 0, 50, 200, 0, 8, 0);
		// reserved cmp4 codes with data equal to the counter: no match
		add(mk(0, 0, 0, 0, 6, 1), 100, 0, 0, 100, 0, 0, 0);
		add(mk(0, 0, 0, 0, 7, 1), 100, 0, 0, 100, 0, 0, 0);
		add(mk(0, 0, 0, 0, 11, 1), 100, 0, 0, 100, 0, 0, 0);
		add(mk(0, 0, 0, 0, 15, 1), 100, 0, 0, 100, 0, 0, 0);
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		// park counters off the condition, program, then step onto it
		foreach (rows[i]) begin
			apb(1'h1, OFS_ENV4, 32'h0);
			cnt_v <= '{default: CW'(rows[i].pre)};
			defl_v <= 16'(rows[i].pre);
			dir_v <= {4{rows[i].up}};
			apb(1'h1, OFS_CMP3, rows[i].d);
			apb(1'h1, OFS_CMP4, rows[i].d);
			apb(1'h1, OFS_ENV4, rows[i].env);
			@(posedge pclk);
			if (rows[i].src == 2) defl_v <= 16'(rows[i].cnt);
			else cnt_v[rows[i].src] <= CW'(rows[i].cnt);
			@(posedge pclk);
			#1;
			chk(32'(cmp_match), 32'(rows[i].m));
			chk({stop_immediate, stop_decel, speed_change},
				rows[i].a);
		end
		apb(1'h1, OFS_ISTAT, 32'h0);
		apb(1'h0, OFS_ISTAT, 32'h0);
		chk(rd, 32'h0000_000c);
		for (int j = 0; j < 4; j++) begin
			apb(1'h1, j < 3 ? OFS_IEN : OFS_ICLR, j < 2 ? 32'h4 >> j : 32'h1f);
			@(posedge pclk);
			#1;
			chk(irq, 32'(!j[0]));
		end
		apb(1'h0, OFS_ISTAT, 32'h0);
		chk(rd, 32'h0);
		// index level in mode 0
		apb(1'h1, OFS_ENV4, 32'h0);
		apb(1'h1, OFS_CMP2, 32'h7);
		cnt_v[3] <= 28'h7;
		@(posedge pclk);
		#1;
		chk(index_output, 32'h1);
		@(posedge pclk);
		cnt_v[3] <= 28'h8;
		@(posedge pclk);
		#1;
		chk(index_output, 32'h0);
		// index pulse in mode 1: either way, up blocked, down, alt code
		apb(1'h1, OFS_CMP4, 32'h1);
		for (int j = 0; j < 4; j++) begin
			@(posedge pclk);
			cnt_v[3] <= 28'h5;
			dir_v <= (j == 1) ? 4'hf : 4'h0;
			apb(1'h1, OFS_ENV4, j == 0 ? 32'h2380_0000 :
				(j == 3 ? 32'h2780_0000 : 32'h2b80_0000));
			@(posedge pclk);
			cnt_v[3] <= 28'h0;
			for (int k = 0; k < 4; k++) begin
				@(posedge pclk);
				#1;
				chk(index_output, 32'(j != 1 && k < 2));
			end
		end
		// software limits override the action field
		apb(1'h1, OFS_ENV4, 32'h0);
		apb(1'h1, OFS_CMP1, 32'h64);
		apb(1'h1, OFS_CMP2, 32'h64);
		cnt_v[0] <= 28'h64;
		for (int j = 0; j < 4; j++) begin
			hs <= (j == 0);
			apb(1'h1, OFS_ENV4, j == 3 ? 32'h1800 :
				(j == 2 ? 32'h18 : 32'h58));
			@(posedge pclk);
			cnt_v[0] <= (j == 3) ? 28'h32 : 28'hc8;
			@(posedge pclk);
			#1;
			chk({stop_immediate, stop_decel}, j ? 32'h2 : 32'h1);
			@(posedge pclk);
			cnt_v[0] <= 28'h64;
		end
		apb(1'h1, 8'h24, 32'hffff_ffff);
		chk(er, 32'h1);
		apb(1'h0, 8'h24, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		apb(1'h1, OFS_ENV4, 32'h5a5a_a5a5);
		apb(1'h0, OFS_ENV4, 32'h0);
		chk(rd, 32'h5a5a_a5a5);
		// second reset in mid run
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, OFS_ENV4, 32'h0);
		chk(rd, RST_ENV4);
		apb(1'h0, OFS_CMP2, 32'h0);
		chk(rd, RST_CMP);
		close_out();
	end
endmodule : test_axis_comparator_three_four_setup
